// ### ssl_host.sv
// Purpose: host end; apb registers drive the three-wire loader
// Assumes: apb slave, pready raised one cycle after setup
// Notes: serial clock made here by a divider from core_clk
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ssl_cfg.svh"
module ssl_host (
  input wire logic core_clk,
  input wire logic nrst,
  ssl_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_reg,
  output logic pready_reg,
  output logic pslverr_reg,
  output logic irq_reg
);
  ssl_pkg::ssl_state_t state_reg;
  ssl_pkg::ssl_state_t state_next;
  logic [23:0] word_reg;
  logic [23:0] shreg_reg;
  logic [4:0] bit_reg;
  logic [2:0] div_reg;
  logic sclk_reg;
  logic serial_data_in_reg;
  logic le_reg;
  logic ce_reg;
  logic lk1_reg;
  logic lk2_reg;
  logic lk_prev_reg;
  logic [2:0] int_stat_reg;
  logic [2:0] int_en_reg;
  logic [16:0] divchk_reg;
  wire tick;
  wire setup;
  wire wr;
  wire busy;
  wire start;
  wire sent;
  wire [2:0] ev;
  wire [2:0] clr;
  wire div_ok;
  wire pre_adv;
  wire known;
  wire [31:0] rd_mux;
  wire [15:0] nval;
  wire pre89;

  // apb decode: answer prepared in setup, write takes effect in access
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_reg & pwrite;
  assign busy = (state_reg != ssl_pkg::SSL_IDLE);
  assign start = wr && paddr == `SSL_OFS_WORD && !busy;
  assign known = paddr == `SSL_OFS_WORD || paddr == `SSL_OFS_STATUS ||
    paddr == `SSL_OFS_INT_STAT || paddr == `SSL_OFS_INT_CLR ||
    paddr == `SSL_OFS_INT_EN || paddr == `SSL_OFS_CHIP_EN ||
    paddr == `SSL_OFS_DIVCHK;
  assign clr = (wr && paddr == `SSL_OFS_INT_CLR) ? pwdata[2:0] : 3'h0;

  // divide value check for the chosen prescaler
  assign nval = divchk_reg[15:0];
  assign pre89 = divchk_reg[`SSL_DIV_PRE_BIT];
  assign div_ok = pre89 ? (nval >= `SSL_NMIN_P89)
                        : (nval >= `SSL_NMIN_P45); // RULE7
  assign pre_adv = (nval < `SSL_NBEST) ? !pre89
    : ((nval > `SSL_NBEST) ? pre89 : 1'h1); // RULE8

  assign rd_mux =
    (paddr == `SSL_OFS_WORD) ? {8'h00, word_reg} :
    (paddr == `SSL_OFS_STATUS) ? {28'h0000000, pre_adv, div_ok,
                                  lk2_reg, busy} :
    (paddr == `SSL_OFS_INT_STAT) ? {29'h00000000, int_stat_reg} :
    (paddr == `SSL_OFS_INT_EN) ? {29'h00000000, int_en_reg} :
    (paddr == `SSL_OFS_CHIP_EN) ? {31'h00000000, ce_reg} :
    (paddr == `SSL_OFS_DIVCHK) ? {15'h0000, divchk_reg} : 32'h00000000;

  // bus answer; a word write while busy is refused with pslverr
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & (!known ||
        (pwrite && paddr == `SSL_OFS_WORD && busy));
      prdata_reg <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // software registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      word_reg <= 24'h000000;
      int_en_reg <= `SSL_INT_EN_RST;
      ce_reg <= `SSL_CHIP_EN_RST;
      divchk_reg <= 17'h00000;
    end else if (wr) begin
      if (start) word_reg <= pwdata[23:0];
      if (paddr == `SSL_OFS_INT_EN) int_en_reg <= pwdata[2:0];
      if (paddr == `SSL_OFS_CHIP_EN) ce_reg <= pwdata[0]; // RULE9
      if (paddr == `SSL_OFS_DIVCHK) divchk_reg <= pwdata[16:0];
    end
  end

  // half-period divider, restarted by each transfer
  assign tick = (div_reg == 3'(`SSL_SCLK_HALF - 1)); // RULE3
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= (start || tick) ? 3'h0 : div_reg + 3'h1;
    end
  end

  // sequencer: strobe low, 24 clocks (three bytes), strobe high
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ssl_pkg::SSL_IDLE: if (start) state_next = ssl_pkg::SSL_LOW;
      ssl_pkg::SSL_LOW: if (tick) state_next = ssl_pkg::SSL_HIGH;
      ssl_pkg::SSL_HIGH: begin
        if (tick) begin
          state_next = (bit_reg == 5'(`SSL_WORD_BITS - 1))
            ? ssl_pkg::SSL_LATCH : ssl_pkg::SSL_LOW;
        end
      end
      ssl_pkg::SSL_LATCH: if (tick) state_next = ssl_pkg::SSL_HOLD;
      ssl_pkg::SSL_HOLD: if (tick) state_next = ssl_pkg::SSL_IDLE;
      default: state_next = ssl_pkg::SSL_IDLE;
    endcase
  end

  assign sent = tick && state_reg == ssl_pkg::SSL_LATCH;

  // pin drive; data changes only while the serial clock is low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ssl_pkg::SSL_IDLE;
      shreg_reg <= 24'h000000;
      bit_reg <= 5'h00;
      sclk_reg <= 1'h0;
      serial_data_in_reg <= 1'h0;
      le_reg <= 1'h1;
    end else begin
      state_reg <= state_next;
      if (start) begin
        le_reg <= 1'h0; // RULE4 RULE5
        shreg_reg <= pwdata[23:0];
        serial_data_in_reg <= pwdata[23]; // RULE11
        bit_reg <= 5'h00;
      end else if (tick && state_reg == ssl_pkg::SSL_LOW) begin
        sclk_reg <= 1'h1;
      end else if (tick && state_reg == ssl_pkg::SSL_HIGH) begin
        sclk_reg <= 1'h0;
        bit_reg <= bit_reg + 5'h01;
        shreg_reg <= {shreg_reg[22:0], 1'b0};
        serial_data_in_reg <= shreg_reg[22];
      end else if (sent) begin
        le_reg <= 1'h1; // RULE6
      end
    end
  end

  // lock line from the device crosses in through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lk1_reg <= 1'h0;
      lk2_reg <= 1'h0;
      lk_prev_reg <= 1'h0;
    end else begin
      lk1_reg <= link.multiplexed_status_out;
      lk2_reg <= lk1_reg; // RULE10
      lk_prev_reg <= lk2_reg;
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  assign ev = {~lk2_reg & lk_prev_reg, lk2_reg & ~lk_prev_reg, sent};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      int_stat_reg <= 3'h0;
      irq_reg <= 1'h0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~clr) | ev;
      irq_reg <= |(((int_stat_reg & ~clr) | ev) & int_en_reg);
    end
  end

  assign link.sclk = sclk_reg;
  assign link.serial_data_in = serial_data_in_reg;
  assign link.latch_strobe = le_reg;
  assign link.chip_enable = ce_reg;
endmodule // ssl_host

// ### ssl_cfg.svh
// Purpose: constants for the synthesizer serial load port, both ends
// Assumes: core_clk at 100 MHz; all counts derived from printed figures
// Notes: offsets are byte addresses of the controller's apb registers
//
// How it works
// [RULE1] device shifts data in on serial clock rise
// [RULE2] latch strobe rise copies word to latch
// [RULE3] host serial clock never above 20 MHz
// [RULE4] host drives latch strobe low before shifting
// [RULE5] byte hosts send three bytes, strobe low
// [RULE6] host raises latch strobe after last byte
// [RULE7] integer value minimum 31 or 91 per prescaler
// [RULE8] prescaler 4/5 below 91, 8/9 above
// [RULE9] chip enable input powers device down
// [RULE10] status output carries lock, host polls it
// [RULE11] words go most significant bit first
`ifndef SSL_CFG_SVH
`define SSL_CFG_SVH

`define SSL_CLK_MHZ 100
`define SSL_SCLK_MAX_MHZ 20
// half period of the serial clock, rounded up so the rate stays below max
`define SSL_SCLK_HALF ((`SSL_CLK_MHZ + 2 * `SSL_SCLK_MAX_MHZ - 1) / \
  (2 * `SSL_SCLK_MAX_MHZ))
`define SSL_WORD_BITS 24
`define SSL_BYTE_BITS 8
`define SSL_CTRL_BITS 3
`define SSL_NUM_LATCH 7
`define SSL_NMIN_P45 16'h001f
`define SSL_NMIN_P89 16'h005b
`define SSL_NBEST 16'h005b

`define SSL_OFS_WORD 8'h00
`define SSL_OFS_STATUS 8'h04
`define SSL_OFS_INT_STAT 8'h08
`define SSL_OFS_INT_CLR 8'h0c
`define SSL_OFS_INT_EN 8'h10
`define SSL_OFS_CHIP_EN 8'h14
`define SSL_OFS_DIVCHK 8'h18

`define SSL_ST_BUSY 0
`define SSL_ST_LOCK 1
`define SSL_ST_DIV_OK 2
`define SSL_ST_PRE_ADV 3
`define SSL_INT_SENT 0
`define SSL_INT_LOCK_UP 1
`define SSL_INT_LOCK_DN 2
`define SSL_DIV_PRE_BIT 16

`define SSL_CHIP_EN_RST 1'h1
`define SSL_INT_EN_RST 3'h0

`endif

// ### ssl_pkg.sv
// Purpose: shared types for the serial load port
// Assumes: nothing beyond ssl_cfg.svh
// Notes: host sequencer states plus the 24-bit word type
package ssl_pkg;
  typedef enum logic [2:0] {
    SSL_IDLE = 3'b000,
    SSL_LOW = 3'b001,
    SSL_HIGH = 3'b010,
    SSL_LATCH = 3'b011,
    SSL_HOLD = 3'b100
  } ssl_state_t;
  typedef logic [23:0] ssl_word_t;
endpackage

// ### ssl_if.sv
// Purpose: three-wire load link plus chip enable and status line
// Assumes: every wire has a single driving end
// Notes: no clocking block; each end samples what it receives
`timescale 1ns/1ps
interface ssl_if;
  logic sclk;
  logic serial_data_in;
  logic latch_strobe;
  logic chip_enable;
  logic multiplexed_status_out;
  modport dev (
    input sclk,
    input serial_data_in,
    input latch_strobe,
    input chip_enable,
    output multiplexed_status_out
  );
  modport host (
    output sclk,
    output serial_data_in,
    output latch_strobe,
    output chip_enable,
    input multiplexed_status_out
  );
endinterface

// ### ssl_dev.sv
// Purpose: device end; shift register, latch bank, power-down, status
// Assumes: link pins are asynchronous to core_clk, serial clock <= 20 MHz
// Notes: each pin passes two flops; edges found on synced copies
`timescale 1ns/1ps
`include "ssl_cfg.svh"
module ssl_dev (
  input wire logic core_clk,
  input wire logic nrst,
  ssl_if.dev link,
  input wire logic lock_detect,
  input wire logic [2:0] rd_index,
  output logic [23:0] rd_data_reg,
  output logic [23:0] last_word_reg,
  output logic [2:0] last_index_reg,
  output logic load_pulse_reg,
  output logic power_down_reg
);
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic sclk_prev_reg;
  logic le_prev_reg;
  logic [23:0] shift_reg;
  logic [23:0] bank_reg [0:`SSL_NUM_LATCH-1];
  logic mux_reg;
  wire sclk_rise;
  wire le_rise;
  wire [2:0] sel;
  wire sel_ok;
  wire rd_ok;

  // two-flop synchronisers: sclk, data, strobe, chip enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // strobe bit resets high, its idle level, so no load follows reset
      s1_reg <= 4'h4;
      s2_reg <= 4'h4;
    end else begin
      s1_reg <= {link.chip_enable, link.latch_strobe,
                 link.serial_data_in, link.sclk};
      s2_reg <= s1_reg;
    end
  end

  // edge finding on the second stage only
  assign sclk_rise = s2_reg[0] & ~sclk_prev_reg;
  assign le_rise = s2_reg[2] & ~le_prev_reg;
  // control bits sit lowest since words arrive msb first
  assign sel = shift_reg[`SSL_CTRL_BITS-1:0]; // RULE11
  assign sel_ok = (sel < 3'(`SSL_NUM_LATCH));
  assign rd_ok = (rd_index < 3'(`SSL_NUM_LATCH));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_reg <= 1'h0;
      le_prev_reg <= 1'h1; // matches the idle strobe, avoids a false rise
    end else begin
      sclk_prev_reg <= s2_reg[0];
      le_prev_reg <= s2_reg[2];
    end
  end

  // shift in; older bits move up so the first bit ends at bit 23
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= 24'h000000;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[22:0], s2_reg[1]}; // RULE1 RULE11
    end
  end

  // latch bank; an unused control code loads nothing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `SSL_NUM_LATCH; i++) begin
        bank_reg[i] <= 24'h000000;
      end
    end else if (le_rise && sel_ok) begin
      bank_reg[sel] <= shift_reg; // RULE2
    end
  end

  // user-side record of each transfer into a latch
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      last_word_reg <= 24'h000000;
      last_index_reg <= 3'h0;
      load_pulse_reg <= 1'h0;
      rd_data_reg <= 24'h000000;
    end else begin
      load_pulse_reg <= le_rise & sel_ok;
      if (le_rise && sel_ok) begin
        last_word_reg <= shift_reg;
        last_index_reg <= sel;
      end
      rd_data_reg <= rd_ok ? bank_reg[rd_index] : 24'h000000;
    end
  end

  // power-down keeps latch contents but silences the status line
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      power_down_reg <= 1'h1;
      mux_reg <= 1'h0;
    end else begin
      power_down_reg <= ~s2_reg[3]; // RULE9
      mux_reg <= s2_reg[3] & lock_detect; // RULE10
    end
  end

  assign link.multiplexed_status_out = mux_reg;
endmodule // ssl_dev

// ### ssl_asserts.sv
// Purpose: wire-level checks on the serial load link
// Assumes: core_clk samples the link; host makes the serial clock
// Notes: frame length counted in helper logic, not in a repetition
`timescale 1ns/1ps
module ssl_asserts (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  input wire logic chip_enable,
  input wire logic multiplexed_status_out
);
  logic sclk_reg;
  logic [5:0] rises_reg;
  logic [5:0] rises_next;
  // count serial clock rises inside one frame; cleared while strobe high
  assign rises_next = latch_strobe ? 6'h00 :
    rises_reg + {5'h00, sclk & ~sclk_reg};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_reg <= 1'h0;
      rises_reg <= 6'h00;
    end else begin
      sclk_reg <= sclk;
      rises_reg <= rises_next;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rise;
    !sclk ##1 sclk;
  endsequence
  sequence s_frame_end;
    !latch_strobe ##1 latch_strobe;
  endsequence
  a_sclk_high_min: assert property (s_rise |-> sclk[*3])
    else $error("serial clock high phase too short");
  a_sclk_low_min: assert property (sclk ##1 !sclk |-> !sclk[*3])
    else $error("serial clock low phase too short");
  a_strobe_low_shift: assert property (s_rise |-> !latch_strobe)
    else $error("serial clock rose with strobe high");
  a_idle_no_clk: assert property (latch_strobe |-> !sclk)
    else $error("serial clock high outside a frame");
  a_data_stable: assert property (
    sclk && $past(sclk) |-> $stable(serial_data_in))
    else $error("data moved while serial clock high");
  a_frame_bits: assert property (s_frame_end |-> rises_reg == 6'h18)
    else $error("frame did not carry 24 bits");
  a_strobe_quiet: assert property (s_frame_end |-> !$past(sclk, 2))
    else $error("strobe rose too soon after last bit");
  a_strobe_hold: assert property (
    $rose(latch_strobe) |-> latch_strobe[*3])
    else $error("strobe high too briefly");
  a_power_down: assert property (
    !chip_enable[*4] |-> !multiplexed_status_out)
    else $error("status line active in power-down");
endmodule // ssl_asserts

// ### tb.sv
// Purpose: drives the host over apb and watches both link ends
// Assumes: pready comes one cycle after setup
// Notes: wire bits gathered on each serial clock rise
`timescale 1ns/1ps
`include "ssl_cfg.svh"
module tb;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic lock_detect = 1'h0;
  logic [2:0] rd_index = 3'h0;
  logic [31:0] prdata_reg, q;
  logic pready_reg, pslverr_reg, irq_reg, e, load_pulse_reg, power_down_reg;
  logic [23:0] rd_data_reg, last_word_reg, mon;
  logic [2:0] last_index_reg;
  int mismatches = 0;
  int num_checks = 0;
  int loads = 0;
  ssl_if lnk();
  ssl_host ssl_host_i (.core_clk(core_clk), .nrst(nrst), .link(lnk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
    .pslverr_reg(pslverr_reg), .irq_reg(irq_reg));
  ssl_dev ssl_dev_i (.core_clk(core_clk), .nrst(nrst), .link(lnk),
    .lock_detect(lock_detect), .rd_index(rd_index),
    .rd_data_reg(rd_data_reg), .last_word_reg(last_word_reg),
    .last_index_reg(last_index_reg), .load_pulse_reg(load_pulse_reg),
    .power_down_reg(power_down_reg));
  ssl_asserts ssl_asserts_i (.core_clk(core_clk), .nrst(nrst),
    .sclk(lnk.sclk), .serial_data_in(lnk.serial_data_in),
    .latch_strobe(lnk.latch_strobe), .chip_enable(lnk.chip_enable),
    .multiplexed_status_out(lnk.multiplexed_status_out));
  // clock, wire capture and load counting
  always #5 core_clk = ~core_clk;
  always @(posedge lnk.sclk) mon <= {mon[22:0], lnk.serial_data_in};
  always @(posedge core_clk) if (load_pulse_reg === 1'h1) loads <= loads + 1;
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer; request held until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready_reg !== 1'h1) @(posedge core_clk);
    q = prdata_reg;
    e = pslverr_reg;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // one word: a second write while busy must be refused
  task send(input logic [23:0] w);
    apb(1'h1, `SSL_OFS_WORD, {8'h00, w});
    apb(1'h1, `SSL_OFS_WORD, 32'h0);
    chk({31'h0, e}, 32'h1);
    do apb(1'h0, `SSL_OFS_STATUS, 32'h0); while (q[0] !== 1'h0);
    repeat (6) @(posedge core_clk);
  endtask
  // reset values, then an unmapped address
  task t_regs;
    apb(1'h0, `SSL_OFS_INT_EN, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, `SSL_OFS_CHIP_EN, 32'h0);
    chk(q, 32'h1);
    apb(1'h0, `SSL_OFS_DIVCHK, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, 8'h1c, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  // every latch code, then the ignored code 7
  task t_load;
    int n;
    logic [23:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {8'ha5, i[7:0], 5'h0b, i[2:0]};
      n = loads;
      send(w);
      chk({8'h00, mon}, {8'h00, w});
      chk(loads - n, {31'h0, i < 7});
      if (i < 7) begin
        chk({8'h00, last_word_reg}, {8'h00, w});
        rd_index <= i[2:0];
        repeat (2) @(posedge core_clk);
        chk({8'h00, rd_data_reg}, {8'h00, w});
      end
    end
    chk({29'h0, last_index_reg}, 32'h6);
  endtask
  // sent events gathered while masked, then unmasked and cleared
  task t_irq;
    chk({31'h0, irq_reg}, 32'h0);
    apb(1'h0, `SSL_OFS_INT_STAT, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    apb(1'h1, `SSL_OFS_INT_EN, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq_reg}, 32'h1);
    apb(1'h1, `SSL_OFS_INT_CLR, 32'h7);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq_reg}, 32'h0);
  endtask
  // divide value limits and prescaler advice at the boundaries
  task t_div;
    logic [16:0] tv[6] = '{17'h0001e, 17'h0001f, 17'h1005a, 17'h1005b,
      17'h0005c, 17'h0005b};
    logic [1:0] ex[6] = '{2'h2, 2'h3, 2'h0, 2'h3, 2'h1, 2'h3};
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, `SSL_OFS_DIVCHK, {15'h0, tv[i]});
      apb(1'h0, `SSL_OFS_STATUS, 32'h0);
      chk({30'h0, q[3:2]}, {30'h0, ex[i]});
    end
  endtask
  // lock seen on the line, then power-down silences it
  task t_pd;
    lock_detect <= 1'h1;
    repeat (6) @(posedge core_clk);
    chk({31'h0, lnk.multiplexed_status_out}, 32'h1);
    apb(1'h0, `SSL_OFS_STATUS, 32'h0);
    chk({31'h0, q[1]}, 32'h1);
    apb(1'h1, `SSL_OFS_CHIP_EN, 32'h0);
    repeat (6) @(posedge core_clk);
    chk({31'h0, lnk.multiplexed_status_out}, 32'h0);
    chk({31'h0, power_down_reg}, 32'h1);
    // lock gained and lock lost both latched, sent was cleared earlier
    apb(1'h0, `SSL_OFS_INT_STAT, 32'h0);
    chk({29'h0, q[2:0]}, 32'h6);
    apb(1'h1, `SSL_OFS_CHIP_EN, 32'h1);
    repeat (6) @(posedge core_clk);
    chk({31'h0, power_down_reg}, 32'h0);
  endtask
  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence after 3 cycles of reset
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'h1;
    t_regs;
    t_load;
    t_irq;
    t_div;
    t_pd;
    test_done;
  end
  // hang guard, far beyond the roughly 1400 cycles needed
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    test_done;
  end
endmodule // tb
